// [sdw_map.svh]
// register map, field positions, reset values and timing constants of the dual watchdog
// assumes byte offsets as seen on both register ports, 16-bit data words
// Contract
// - host watchdog time is 16-bit increment count
// - host watchdog time zero disables it
// - one shared process watchdog, zero disables
// - enabled buffer writes restart process watchdog
// - process status reads 0 when expired
// - write-ack mode: host write clears event bit
// - read-ack mode: host read clears, writes ignored
// - process expiry counter saturates at FF
// - network write to the counter word clears both counters, host writes ignored
// - time registers network writable, host read-only
// - host expiry counter saturates at FF
// - event bit 6 set on process expiry
`ifndef SDW_MAP_SVH
`define SDW_MAP_SVH
`define SDW_OFS_DIVIDER      16'h0400
`define SDW_OFS_HOST_TIME    16'h0410
`define SDW_OFS_PROC_TIME    16'h0420
`define SDW_OFS_PROC_STATUS  16'h0440
`define SDW_OFS_COUNTERS     16'h0442
`define SDW_EVENT_BIT        6
`define SDW_TICK_NS          100000
`define SDW_CLK_NS           10
`define SDW_RST_DIVIDER      16'h270F
`define SDW_RST_TIME         16'h03E8
`define SDW_CNT_MAX          8'hFF
`endif

// [sdw_pkg.sv]
// types shared by the dual watchdog files
// assumes sdw_map.svh is compiled alongside
package sdw_pkg;
    // one register access from either port
    typedef struct packed {
        logic        rd;   // read strobe, one cycle
        logic        wr;   // write strobe, one cycle
        logic [15:0] addr; // byte offset
        logic [15:0] wdata;
    } sdw_acc_t;
    // watchdog counter state, gray coded
    typedef enum logic [1:0] {
        SDW_OFF     = 2'b00,
        SDW_RUN     = 2'b01,
        SDW_EXPIRED = 2'b11
    } sdw_state_t;
endpackage

// [sdw_timer.sv]
// one watchdog: counts shared ticks since restart and flags expiry
// assumes tick is a one-cycle pulse in the clk domain
`timescale 1ns/1ps
`include "sdw_map.svh"
module sdw_timer (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // control
    input  wire logic              tick,
    input  wire logic              restart,
    input  wire logic [15:0]       wd_time,
    // status
    output sdw_pkg::sdw_state_t    state,
    output logic                   expire_pulse
);
    import sdw_pkg::*;
    logic [15:0] ticks; // increments since restart

    // tick count and state; restart outranks a tick in the same cycle
    always_ff @(posedge clk) begin
        expire_pulse <= 1'b0;
        if (sys_rst) begin
            ticks <= 16'h0000;
            state <= SDW_OFF;
        end else if (wd_time == 16'h0000) begin
            ticks <= 16'h0000;
            state <= SDW_OFF;
        end else if (restart) begin
            ticks <= 16'h0000;
            state <= SDW_RUN;
        end else begin
            case (state)
                SDW_OFF: begin
                    // a time just made nonzero arms the watchdog from zero
                    ticks <= 16'h0000;
                    state <= SDW_RUN;
                end
                SDW_RUN: begin
                    if (tick) begin
                        if (ticks + 16'h0001 >= wd_time) begin
                            state        <= SDW_EXPIRED;
                            expire_pulse <= 1'b1;
                        end
                        ticks <= ticks + 16'h0001;
                    end
                end
                SDW_EXPIRED: begin
                    // stays expired until the next restart or a zero time
                    state <= SDW_EXPIRED;
                end
                default: begin
                    // unused code falls back to off
                    ticks <= 16'h0000;
                    state <= SDW_OFF;
                end
            endcase
        end
    end

    property p_off_quiet;
        @(posedge clk) disable iff (sys_rst)
        (wd_time == 16'h0000) |=> !expire_pulse && state != SDW_EXPIRED;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("disabled watchdog expired");

    property p_restart_clears;
        @(posedge clk) disable iff (sys_rst)
        (restart && wd_time != 16'h0000 && $past(wd_time) == wd_time) |=> state == SDW_RUN && ticks == 16'h0000;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not rearm");
endmodule

// [sdw_watchdogs.sv]
// dual watchdog: host interface and process data, with status, event and counters
// assumes both register ports present one-cycle strobes synchronous to clk
`timescale 1ns/1ps
`include "sdw_map.svh"
module sdw_watchdogs #(
    parameter int unsigned TICK_CYCLES = `SDW_TICK_NS / `SDW_CLK_NS // cycles per divider unit at reset
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // network side port
    input  sdw_pkg::sdw_acc_t      net_acc,
    output logic [15:0]            net_rdata,
    // local host interface
    input  sdw_pkg::sdw_acc_t      host_acc,
    input  wire logic              host_any_access,
    input  wire logic              write_ack_mode,
    output logic [15:0]            host_rdata,
    // buffer manager triggers
    input  wire logic              buf_write,
    input  wire logic              buf_trigger_en,
    // status out
    output logic                   event_request,
    output logic                   host_expired,
    output logic                   proc_expired
);
    import sdw_pkg::*;

    // registers and internal state
    logic [15:0] divider;       // clock cycles per tick minus one
    logic [15:0] host_time;     // host watchdog time
    logic [15:0] proc_time;     // process watchdog time
    logic [15:0] div_count;     // running divider
    logic        tick;          // shared increment pulse
    logic [7:0]  proc_count;    // process expiry counter
    logic [7:0]  host_count;    // host expiry counter
    sdw_state_t  host_state;    // host watchdog state
    sdw_state_t  proc_state;    // process watchdog state
    logic        host_exp_p;    // one-cycle host expiry pulse
    logic        proc_exp_p;    // one-cycle process expiry pulse
    logic        proc_rst_trig; // process watchdog restart request

    // decode helper: exact word match on an access
    function automatic logic hit(input sdw_acc_t a, input logic [15:0] ofs);
        hit = (a.addr == ofs);
    endfunction

    // time registers written only from the network side; host writes ignored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divider   <= `SDW_RST_DIVIDER;
            host_time <= `SDW_RST_TIME;
            proc_time <= `SDW_RST_TIME;
        end else if (net_acc.wr) begin
            if (hit(net_acc, `SDW_OFS_DIVIDER))
                divider <= net_acc.wdata;
            if (hit(net_acc, `SDW_OFS_HOST_TIME))
                host_time <= net_acc.wdata;
            if (hit(net_acc, `SDW_OFS_PROC_TIME))
                proc_time <= net_acc.wdata;
        end
    end

    // shared tick: one pulse every divider+1 clocks, so the tick period follows the register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_count <= 16'h0000;
            tick      <= 1'b0;
        end else if (div_count >= divider) begin
            div_count <= 16'h0000;
            tick      <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            tick      <= 1'b0;
        end
    end

    // only buffer writes with triggering enabled restart the process watchdog
    assign proc_rst_trig = buf_write && buf_trigger_en;

    // host interface watchdog, restarted by every host access
    sdw_timer u_host (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .tick         (tick),
        .restart      (host_any_access),
        .wd_time      (host_time),
        .state        (host_state),
        .expire_pulse (host_exp_p)
    );

    // single process watchdog shared by all buffer managers
    sdw_timer u_proc (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .tick         (tick),
        .restart      (proc_rst_trig),
        .wd_time      (proc_time),
        .state        (proc_state),
        .expire_pulse (proc_exp_p)
    );

    // event request bit: expiry wins over an acknowledge in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst)
            event_request <= 1'b0;
        else if (proc_exp_p)
            event_request <= 1'b1;
        else if (write_ack_mode && host_acc.wr && hit(host_acc, `SDW_OFS_PROC_STATUS))
            event_request <= 1'b0;
        else if (!write_ack_mode && host_acc.rd && hit(host_acc, `SDW_OFS_PROC_STATUS))
            event_request <= 1'b0;
    end

    // expiry counters; a network write to the counter word at 0x0442 clears both, an expiry then still counts from zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            proc_count <= 8'h00;
            host_count <= 8'h00;
        end else begin
            if (net_acc.wr && hit(net_acc, `SDW_OFS_COUNTERS)) begin
                proc_count <= {7'h00, proc_exp_p};
                host_count <= {7'h00, host_exp_p};
            end else begin
                if (proc_exp_p && proc_count != `SDW_CNT_MAX)
                    proc_count <= proc_count + 8'h01;
                if (host_exp_p && host_count != `SDW_CNT_MAX)
                    host_count <= host_count + 8'h01;
            end
        end
    end

    // read mux: registered data, one cycle after the strobe
    function automatic logic [15:0] rd_mux(input logic [15:0] addr, input logic [15:0] div,
                                           input logic [15:0] ht, input logic [15:0] pt,
                                           input logic pexp, input logic [7:0] pc,
                                           input logic [7:0] hc);
        case (addr)
            `SDW_OFS_DIVIDER:     rd_mux = div;
            `SDW_OFS_HOST_TIME:   rd_mux = ht;
            `SDW_OFS_PROC_TIME:   rd_mux = pt;
            `SDW_OFS_PROC_STATUS: rd_mux = {15'h0000, !pexp};
            `SDW_OFS_COUNTERS:    rd_mux = {hc, pc};
            default:              rd_mux = 16'h0000;          // unmapped reads zero
        endcase
    endfunction

    // both read ports and status flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            net_rdata    <= 16'h0000;
            host_rdata   <= 16'h0000;
            host_expired <= 1'b0;
            proc_expired <= 1'b0;
        end else begin
            net_rdata    <= rd_mux(net_acc.addr, divider, host_time, proc_time,
                                   proc_state == SDW_EXPIRED, proc_count, host_count);
            host_rdata   <= rd_mux(host_acc.addr, divider, host_time, proc_time,
                                   proc_state == SDW_EXPIRED, proc_count, host_count);
            host_expired <= (host_state == SDW_EXPIRED);
            proc_expired <= (proc_state == SDW_EXPIRED);
        end
    end

    // checks on the event bit, the counters, the time registers and the tick
    property p_event_set;
        @(posedge clk) disable iff (sys_rst)
        proc_exp_p |=> event_request;
    endproperty
    a_event_set: assert property (p_event_set) else $error("event bit not set on expiry");

    property p_wr_ignored;
        @(posedge clk) disable iff (sys_rst)
        (!write_ack_mode && event_request && !proc_exp_p && !host_acc.rd) |=> event_request;
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("event bit cleared without read");

    property p_host_ro;
        @(posedge clk) disable iff (sys_rst)
        !net_acc.wr |=> $stable(host_time) && $stable(proc_time);
    endproperty
    a_host_ro: assert property (p_host_ro) else $error("time changed without network write");

    property p_sat;
        @(posedge clk) disable iff (sys_rst)
        (proc_count == 8'hFF && !net_acc.wr) |=> proc_count == 8'hFF;
    endproperty
    a_sat: assert property (p_sat) else $error("process counter wrapped");

    property p_host_sat;
        @(posedge clk) disable iff (sys_rst)
        (host_count == 8'hFF && !net_acc.wr) |=> host_count == 8'hFF;
    endproperty
    a_host_sat: assert property (p_host_sat) else $error("host counter wrapped");

    property p_clear_both;
        @(posedge clk) disable iff (sys_rst)
        (net_acc.wr && net_acc.addr == `SDW_OFS_COUNTERS && !proc_exp_p && !host_exp_p)
            |=> proc_count == 8'h00 && host_count == 8'h00;
    endproperty
    a_clear_both: assert property (p_clear_both) else $error("counters not cleared");

    property p_wack;
        @(posedge clk) disable iff (sys_rst)
        (write_ack_mode && host_acc.wr && host_acc.addr == 16'h0440 && !proc_exp_p) |=> !event_request;
    endproperty
    a_wack: assert property (p_wack) else $error("write ack did not clear");

    property p_tick_spacing;
        @(posedge clk) disable iff (sys_rst)
        (tick && divider == 16'h0001 && $stable(divider)) |=> !tick ##1 tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick period wrong");

    property p_read_ack;
        @(posedge clk) disable iff (sys_rst)
        (!write_ack_mode && host_acc.rd && host_acc.addr == `SDW_OFS_PROC_STATUS && !proc_exp_p)
            |=> !event_request;
    endproperty
    a_read_ack: assert property (p_read_ack) else $error("read ack did not clear");

    property p_status_read;
        @(posedge clk) disable iff (sys_rst)
        (host_acc.rd && host_acc.addr == `SDW_OFS_PROC_STATUS) |=> host_rdata == {15'h0000, !proc_expired};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read disagrees with expiry");

    property p_proc_count_step;
        @(posedge clk) disable iff (sys_rst)
        (proc_exp_p && proc_count != 8'hFF && !(net_acc.wr && net_acc.addr == `SDW_OFS_COUNTERS))
            |=> proc_count == $past(proc_count) + 8'h01;
    endproperty
    a_proc_count_step: assert property (p_proc_count_step) else $error("process counter missed an expiry");
endmodule

// [sdw_port_model.sv]
// partner model: network master and local host issuing register accesses
// assumes read data is registered one cycle after the address edge
`timescale 1ns/1ps
module sdw_port_model (
    // clock
    input  wire logic           clk,
    // access strobes toward the block
    output sdw_pkg::sdw_acc_t   net_acc,
    output sdw_pkg::sdw_acc_t   host_acc,
    output logic                host_any_access,
    // read data from the block
    input  wire logic [15:0]    net_rdata,
    input  wire logic [15:0]    host_rdata
);
    import sdw_pkg::*;
    // idle bus at time zero
    initial begin
        net_acc = '0;
        host_acc = '0;
        host_any_access = 1'b0;
    end
    // one access held across one edge; idle address and data are inverted so stale values never match
    task automatic acc(input logic hst, input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        sdw_acc_t r;
        @(posedge clk);
        #1;
        r = '{rd: ~wr, wr: wr, addr: a, wdata: d};
        if (hst) begin
            host_acc = r;
        end else begin
            net_acc = r;
        end
        host_any_access = hst;
        @(posedge clk);
        #1;
        q = hst ? host_rdata : net_rdata;
        r = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        if (hst) begin
            host_acc = r;
        end else begin
            net_acc = r;
        end
        host_any_access = 1'b0;
    endtask
endmodule

// [slave_dual_watchdog_tb.sv]
// self-checking bench for the dual watchdog
// assumes sdw_port_model drives both register ports
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
    $display("mismatch %s exp %h got %h", nm, ex, gt); failures++; end end
module slave_dual_watchdog_tb;
    import sdw_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, write_ack_mode = 1'b0, buf_write = 1'b0, buf_trigger_en = 1'b0;
    sdw_acc_t net_acc, host_acc;
    logic host_any_access, event_request, host_expired, proc_expired;
    logic [15:0] net_rdata, host_rdata, q;
    int failures = 0, samples_checked = 0, cycles = 0;
    // clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end
    sdw_watchdogs dut_u (.clk(clk), .sys_rst(sys_rst), .net_acc(net_acc), .net_rdata(net_rdata),
        .host_acc(host_acc), .host_any_access(host_any_access), .write_ack_mode(write_ack_mode),
        .host_rdata(host_rdata), .buf_write(buf_write), .buf_trigger_en(buf_trigger_en),
        .event_request(event_request), .host_expired(host_expired), .proc_expired(proc_expired));
    sdw_port_model pm_u (.clk(clk), .net_acc(net_acc), .host_acc(host_acc),
        .host_any_access(host_any_access), .net_rdata(net_rdata), .host_rdata(host_rdata));
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one buffer write pulse with the given trigger enable
    task automatic pulse_buf(input logic en);
        @(posedge clk);
        #1;
        buf_trigger_en = en;
        buf_write = 1'b1;
        wait_cyc(1);
        buf_write = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    // reset values from both ports, unmapped offset reads zero
    task automatic t_reset;
        logic [15:0] a[6] = '{16'h0400, 16'h0410, 16'h0420, 16'h0440, 16'h0442, 16'h0600};
        logic [15:0] e[6] = '{16'h270F, 16'h03E8, 16'h03E8, 16'h0001, 16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            pm_u.acc(1'b0, 1'b0, a[i], 16'h0000, q);
            `CHK("net reset read", e[i], q)
            pm_u.acc(1'b1, 1'b0, a[i], 16'h0000, q);
            `CHK("host reset read", e[i], q)
        end
    endtask
    // host cannot write times; zero host time keeps that watchdog off
    task automatic t_setup;
        pm_u.acc(1'b1, 1'b1, 16'h0420, 16'h0005, q);
        pm_u.acc(1'b0, 1'b0, 16'h0420, 16'h0000, q);
        `CHK("proc time after host write", 16'h03E8, q)
        pm_u.acc(1'b0, 1'b1, 16'h0400, 16'h0001, q);
        pm_u.acc(1'b0, 1'b1, 16'h0410, 16'h0000, q);
        pm_u.acc(1'b0, 1'b1, 16'h0420, 16'h0002, q);
        wait_cyc(40);
        `CHK("host off when zero", 1'b0, host_expired)
    endtask
    // untriggered writes do not restart; read acknowledge clears the event
    task automatic t_proc_read_ack;
        repeat (8) pulse_buf(1'b0);
        `CHK("proc expired", 1'b1, proc_expired)
        `CHK("event set", 1'b1, event_request)
        pm_u.acc(1'b0, 1'b0, 16'h0440, 16'h0000, q);
        `CHK("status expired", 16'h0000, q)
        `CHK("net read keeps event", 1'b1, event_request)
        write_ack_mode = 1'b0;
        pm_u.acc(1'b1, 1'b1, 16'h0440, 16'h0000, q);
        `CHK("write ignored", 1'b1, event_request)
        pm_u.acc(1'b1, 1'b0, 16'h0440, 16'h0000, q);
        wait_cyc(1);
        `CHK("read clears", 1'b0, event_request)
    endtask
    // triggered writes keep it alive; write acknowledge clears the event
    task automatic t_proc_write_ack;
        repeat (20) pulse_buf(1'b1);
        `CHK("kept alive", 1'b0, proc_expired)
        wait_cyc(12);
        `CHK("expired again", 1'b1, proc_expired)
        write_ack_mode = 1'b1;
        pm_u.acc(1'b1, 1'b0, 16'h0440, 16'h0000, q);
        `CHK("read keeps event", 1'b1, event_request)
        pm_u.acc(1'b1, 1'b1, 16'h0440, 16'h0000, q);
        wait_cyc(1);
        `CHK("write clears", 1'b0, event_request)
    endtask
    // host accesses restart the host watchdog; idle lets it expire
    task automatic t_host;
        pm_u.acc(1'b0, 1'b1, 16'h0410, 16'h0003, q);
        repeat (10) pm_u.acc(1'b1, 1'b0, 16'h0400, 16'h0000, q);
        `CHK("host kept alive", 1'b0, host_expired)
        wait_cyc(14);
        `CHK("host expired", 1'b1, host_expired)
        pm_u.acc(1'b0, 1'b0, 16'h0442, 16'h0000, q);
        `CHK("counters", 16'h0102, q)
    endtask
    // both counters saturate, host writes leave them, a network write clears both
    task automatic t_counters;
        repeat (260) begin
            pulse_buf(1'b1);
            pm_u.acc(1'b1, 1'b0, 16'h0400, 16'h0000, q);
            wait_cyc(10);
        end
        pm_u.acc(1'b0, 1'b0, 16'h0442, 16'h0000, q);
        `CHK("proc count saturated", 8'hFF, q[7:0])
        `CHK("host count saturated", 8'hFF, q[15:8])
        pm_u.acc(1'b0, 1'b1, 16'h0410, 16'h0000, q);
        pm_u.acc(1'b1, 1'b1, 16'h0442, 16'h0000, q);
        pm_u.acc(1'b0, 1'b0, 16'h0442, 16'h0000, q);
        `CHK("host write keeps counters", 16'hFFFF, q)
        pm_u.acc(1'b0, 1'b1, 16'h0442, 16'h0055, q);
        pm_u.acc(1'b0, 1'b0, 16'h0442, 16'h0000, q);
        `CHK("both counters cleared", 16'h0000, q)
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_setup();
        t_proc_read_ack();
        t_proc_write_ack();
        t_host();
        t_counters();
        report_and_stop();
    end
endmodule
